// ==== design/rdc_config.sv ====
// mode pins, serial bus target and two configuration registers of the redriver switch
// Notes on behaviour
// - display pin low, usb pin high: route the usb path only
// - both mode pins high: usb path plus two display lanes
// - display pin high, usb pin low: four display lanes, no usb
// - orientation pin high selects flipped mapping, low unflipped, in every pin-mode configuration; register mode uses general bit 2
// - general bit 4: 0 pin-sampled equaliser levels, 1 register levels; resets 0
// - general bit 3: 0 display enable from upper config bit, 1 from pin
// - lane config 00 off, 01 usb (reset), 10 four display, 11 two display plus usb
// - eq register bits 7:4 lane 1 level: mirror pins or software value
// - eq register bits 3:0 lane 3 level: mirror pins or software value
// - update-type fields change by hardware regardless of software writes
// - general register at 0x0a resets to 0x01; reserved upper bits read-only
// - target address 0x12 with both straps floating; other straps other addresses
`timescale 1ns/1ps
`default_nettype none
module rdc_config (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_i2c_mode,
  input wire logic i_display_mode_pin,
  input wire logic i_usb_mode_pin,
  input wire logic i_orientation_pin,
  input wire logic [1:0] i_display_eq_pins,
  input wire logic [1:0] i_address_strap_high,
  input wire logic [1:0] i_address_strap_low,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  output rdc_pkg::rdc_route_t o_route,
  output logic [3:0] o_dp1_eq,
  output logic [3:0] o_dp3_eq
);
  import rdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling after reset

  logic sampled_reg, sampled_next;
  logic [1:0] eq_pins_reg, eq_pins_next;
  logic [6:0] tgt_addr_reg, tgt_addr_next;

  always_comb begin
    sampled_next = 1'b1;
    eq_pins_next = eq_pins_reg;
    tgt_addr_next = tgt_addr_reg;
    if (!sampled_reg) begin
      eq_pins_next = i_display_eq_pins;
      tgt_addr_next = 7'(TGT_ADDR_BASE + STRAP_HI_WEIGHT * {5'h00, i_address_strap_high}
                         + {5'h00, i_address_strap_low});
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sampled_reg <= 1'b0;
      eq_pins_reg <= 2'h0;
      tgt_addr_reg <= 7'h00;
    end else begin
      sampled_reg <= sampled_next;
      eq_pins_reg <= eq_pins_next;
      tgt_addr_reg <= tgt_addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial bus target

  rdc_state_t state_reg, state_next;
  logic scl_q_reg, sda_q_reg;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic is_addr_reg, is_addr_next;
  logic have_ptr_reg, have_ptr_next;
  logic to_tx_reg, to_tx_next;
  logic nack_reg, nack_next;
  logic drive_reg, drive_next;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] gen_reg, gen_next;
  logic [7:0] eq_reg, eq_next;

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = i_scl & ~scl_q_reg;
  assign scl_fall = ~i_scl & scl_q_reg;
  assign bus_start = scl_q_reg & i_scl & sda_q_reg & ~i_sda;
  assign bus_stop = scl_q_reg & i_scl & ~sda_q_reg & i_sda;

  always_comb begin
    case (ptr_reg)
      GEN_CTRL_OFS: rd_data = gen_reg;
      DP13_EQ_OFS: rd_data = eq_reg;
      default: rd_data = UNMAPPED_RD;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    is_addr_next = is_addr_reg;
    have_ptr_next = have_ptr_reg;
    to_tx_next = to_tx_reg;
    nack_next = nack_reg;
    drive_next = drive_reg;
    wr_en = 1'b0;
    wr_addr = ptr_reg;
    wr_data = shift_reg;
    if (bus_start) begin
      state_next = ST_RX;
      cnt_next = 3'h0;
      is_addr_next = 1'b1;
      have_ptr_next = 1'b0;
      drive_next = 1'b0;
    end else if (bus_stop) begin
      state_next = ST_IDLE;
      drive_next = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          drive_next = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], i_sda};
            cnt_next = 3'(cnt_reg + 3'h1);
            if (cnt_reg == 3'h7) begin
              state_next = ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (scl_fall) begin
            if (is_addr_reg) begin
              if (shift_reg[7:1] == tgt_addr_reg) begin
                drive_next = 1'b1;
                to_tx_next = shift_reg[0];
                state_next = ST_ACK;
              end else begin
                state_next = ST_IDLE;
              end
            end else begin
              drive_next = 1'b1;
              to_tx_next = 1'b0;
              state_next = ST_ACK;
              if (!have_ptr_reg) begin
                ptr_next = shift_reg;
                have_ptr_next = 1'b1;
              end else begin
                wr_en = 1'b1;
                ptr_next = 8'(ptr_reg + 8'h01);
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            is_addr_next = 1'b0;
            cnt_next = 3'h0;
            if (to_tx_reg) begin
              shift_next = rd_data;
              drive_next = ~rd_data[7];
              ptr_next = 8'(ptr_reg + 8'h01);
              state_next = ST_TX;
            end else begin
              drive_next = 1'b0;
              state_next = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            cnt_next = 3'(cnt_reg + 3'h1);
            shift_next = {shift_reg[6:0], 1'b0};
            if (cnt_reg == 3'h7) begin
              drive_next = 1'b0;
              state_next = ST_TXACK;
            end else begin
              drive_next = ~shift_reg[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            nack_next = i_sda;
          end
          if (scl_fall) begin
            if (nack_reg) begin
              state_next = ST_IDLE;
            end else begin
              cnt_next = 3'h0;
              shift_next = rd_data;
              drive_next = ~rd_data[7];
              ptr_next = 8'(ptr_reg + 8'h01);
              state_next = ST_TX;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      is_addr_reg <= 1'b0;
      have_ptr_reg <= 1'b0;
      to_tx_reg <= 1'b0;
      nack_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      scl_q_reg <= i_scl;
      sda_q_reg <= i_sda;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      is_addr_reg <= is_addr_next;
      have_ptr_reg <= have_ptr_next;
      to_tx_reg <= to_tx_next;
      nack_reg <= nack_next;
      drive_reg <= drive_next;
    end
  end

  // open drain: only ever pulls low
  assign o_sda = 1'b0;
  assign o_sda_oe_n = ~drive_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [3:0] eq_mirror;
  assign eq_mirror = {2'h0, eq_pins_reg};

  always_comb begin
    gen_next = gen_reg;
    eq_next = eq_reg;
    // plain read/write fields: eq value stored whole only while general bit 4 is 1, general value masked to bits 4:0
    if (wr_en && wr_addr == GEN_CTRL_OFS) begin
      gen_next = wr_data & GEN_WR_MASK;
    end
    if (!gen_reg[EQ_SRC_BIT]) begin
      eq_next[LANE1_EQ_HI:LANE1_EQ_LO] = eq_mirror;
      eq_next[LANE3_EQ_HI:LANE3_EQ_LO] = eq_mirror;
    end else if (wr_en && wr_addr == DP13_EQ_OFS) begin
      eq_next = wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lane routing

  logic [1:0] cfg;
  rdc_route_t route_next;

  always_comb begin
    if (!i_i2c_mode) begin
      cfg = {i_display_mode_pin, i_usb_mode_pin};
      route_next.flip = i_orientation_pin;
    end else begin
      cfg = gen_reg[LANE_CFG_HI:LANE_CFG_LO];
      if (gen_reg[DP_EN_SRC_BIT]) begin
        cfg[1] = i_display_mode_pin;
      end
      route_next.flip = gen_reg[ORIENT_BIT];
    end
    case (cfg)
      CFG_OFF: begin
        route_next.usb_en = 1'b0;
        route_next.dp_en = 1'b0;
        route_next.dp_four_lane = 1'b0;
      end
      CFG_USB: begin
        route_next.usb_en = 1'b1;
        route_next.dp_en = 1'b0;
        route_next.dp_four_lane = 1'b0;
      end
      CFG_DP4: begin
        route_next.usb_en = 1'b0;
        route_next.dp_en = 1'b1;
        route_next.dp_four_lane = 1'b1;
      end
      CFG_USB_DP2: begin
        route_next.usb_en = 1'b1;
        route_next.dp_en = 1'b1;
        route_next.dp_four_lane = 1'b0;
      end
      default: begin
        route_next.usb_en = 1'b0;
        route_next.dp_en = 1'b0;
        route_next.dp_four_lane = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      gen_reg <= GEN_CTRL_RST;
      eq_reg <= DP13_EQ_RST;
      o_route <= ROUTE_RST;
    end else begin
      gen_reg <= gen_next;
      eq_reg <= eq_next;
      o_route <= route_next;
    end
  end

  assign o_dp1_eq = eq_reg[LANE1_EQ_HI:LANE1_EQ_LO];
  assign o_dp3_eq = eq_reg[LANE3_EQ_HI:LANE3_EQ_LO];
endmodule
`default_nettype wire

// ==== design/rdc_pkg.sv ====
// shared constants and types of the redriver mode and equaliser configuration block
package rdc_pkg;
  // serial bus register map
  localparam logic [7:0] GEN_CTRL_OFS = 8'h0a;
  localparam logic [7:0] DP13_EQ_OFS = 8'h10;
  localparam logic [7:0] GEN_CTRL_RST = 8'h01;
  localparam logic [7:0] DP13_EQ_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // general_mode_control field positions
  localparam int EQ_SRC_BIT = 4;
  localparam int DP_EN_SRC_BIT = 3;
  localparam int ORIENT_BIT = 2;
  localparam int LANE_CFG_HI = 1;
  localparam int LANE_CFG_LO = 0;
  localparam logic [7:0] GEN_WR_MASK = 8'h1f;

  // display_lane1_lane3_eq field positions
  localparam int LANE1_EQ_HI = 7;
  localparam int LANE1_EQ_LO = 4;
  localparam int LANE3_EQ_HI = 3;
  localparam int LANE3_EQ_LO = 0;

  // lane configuration codes
  localparam logic [1:0] CFG_OFF = 2'h0;
  localparam logic [1:0] CFG_USB = 2'h1;
  localparam logic [1:0] CFG_DP4 = 2'h2;
  localparam logic [1:0] CFG_USB_DP2 = 2'h3;

  // strap level codes and target address arithmetic
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [6:0] TGT_ADDR_BASE = 7'h0e;
  localparam logic [6:0] STRAP_HI_WEIGHT = 7'h03;

  // resulting datapath routing
  typedef struct packed {
    logic usb_en;
    logic dp_en;
    logic dp_four_lane;
    logic flip;
  } rdc_route_t;

  localparam rdc_route_t ROUTE_RST = '{usb_en: 1'b0, dp_en: 1'b0, dp_four_lane: 1'b0, flip: 1'b0};

  // serial target states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RX = 6'b000010,
    ST_GAP = 6'b000100,
    ST_ACK = 6'b001000,
    ST_TX = 6'b010000,
    ST_TXACK = 6'b100000
  } rdc_state_t;
endpackage

// ==== tb/rdc_config_asserts.sv ====
// assertion checker for the redriver mode and equaliser configuration block
`timescale 1ns/1ps
`default_nettype none
module rdc_config_asserts (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_i2c_mode,
  input wire logic i_display_mode_pin,
  input wire logic i_usb_mode_pin,
  input wire logic i_orientation_pin,
  input wire logic [1:0] i_display_eq_pins,
  input wire logic [1:0] i_address_strap_high,
  input wire logic [1:0] i_address_strap_low,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  input wire rdc_pkg::rdc_route_t o_route,
  input wire logic [3:0] o_dp1_eq,
  input wire logic [3:0] o_dp3_eq
);
  import rdc_pkg::*;
  logic armed_reg, seen_reg, seen_next, sda_reg;
  logic [1:0] cap_reg, cap_next;
  // equaliser pins captured at the first edge out of reset, bus activity tracked
  always_comb begin
    cap_next = armed_reg ? cap_reg : i_display_eq_pins;
    seen_next = seen_reg | (i_scl & sda_reg & !i_sda);
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      armed_reg <= 1'b0;
      seen_reg <= 1'b0;
      sda_reg <= 1'b1;
      cap_reg <= 2'h0;
    end else begin
      armed_reg <= 1'b1;
      seen_reg <= seen_next;
      sda_reg <= i_sda;
      cap_reg <= cap_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence ack_low_s;
    !o_sda_oe_n [*4];
  endsequence
  reset_values_a: assert property ($rose(i_nrst) |-> o_route == ROUTE_RST && o_sda_oe_n)
    else $error("outputs not at reset value");
  route_usb_a: assert property (!i_i2c_mode && !i_display_mode_pin && i_usb_mode_pin
    |=> o_route == {3'b100, $past(i_orientation_pin)}) else $error("usb only route wrong");
  route_both_a: assert property (!i_i2c_mode && i_display_mode_pin && i_usb_mode_pin
    |=> o_route == {3'b110, $past(i_orientation_pin)}) else $error("usb plus two route wrong");
  route_four_a: assert property (!i_i2c_mode && i_display_mode_pin && !i_usb_mode_pin
    |=> o_route == {3'b011, $past(i_orientation_pin)}) else $error("four lane route wrong");
  route_off_a: assert property (!i_i2c_mode && !i_display_mode_pin && !i_usb_mode_pin
    |=> o_route == {3'b000, $past(i_orientation_pin)}) else $error("off route wrong");
  eq_mirror_a: assert property (armed_reg && !seen_reg |-> ##2
    o_dp1_eq == {2'h0, cap_reg} && o_dp3_eq == {2'h0, cap_reg}) else $error("eq mirror wrong");
  data_turn_a: assert property ($changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl))
    else $error("data drive changed while clock high");
  ack_hold_a: assert property ($fell(o_sda_oe_n) |-> ack_low_s)
    else $error("data drive released too early");
endmodule
bind rdc_config rdc_config_asserts chk_i (.i_clk_sys, .i_nrst, .i_i2c_mode,
  .i_display_mode_pin, .i_usb_mode_pin, .i_orientation_pin, .i_display_eq_pins,
  .i_address_strap_high, .i_address_strap_low, .i_scl, .i_sda, .o_sda, .o_sda_oe_n,
  .o_route, .o_dp1_eq, .o_dp3_eq);
`default_nettype wire

// ==== tb/rdc_i2c_master.sv ====
// serial bus controller model standing in for the port controller
`timescale 1ns/1ps
`default_nettype none
module rdc_i2c_master (
  input wire logic i_clk_sys,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe_n
);
  int half = 4;
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end
  task automatic put(input logic c, input logic d);
    o_scl <= c;
    o_sda_oe_n <= d;
    repeat (half) @(posedge i_clk_sys);
  endtask
  task automatic start();
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
    put(1'b0, 1'b0);
  endtask
  task automatic stop();
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
  endtask
  // data moves only while the clock is low; sampled at the end of the high phase
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ackd);
    for (int i = 8; i >= 0; i--) begin
      put(1'b0, (i == 0) ? last : d[i-1]);
      put(1'b1, (i == 0) ? last : d[i-1]);
      if (i > 0) q[i-1] = i_sda;
      ackd = !i_sda;
      put(1'b0, (i == 0) ? last : d[i-1]);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/rdc_config_tb.sv ====
// self-checking bench for the redriver mode and equaliser configuration block
`timescale 1ns/1ps
`default_nettype none
module rdc_config_tb;
  import rdc_pkg::*;
  logic i_clk_sys, i_nrst, i_i2c_mode, i_display_mode_pin, i_usb_mode_pin, i_orientation_pin;
  logic [1:0] i_display_eq_pins, i_address_strap_high, i_address_strap_low, eq_set;
  logic i_scl, o_sda, o_sda_oe_n, m_oe_n;
  wire logic i_sda;
  rdc_route_t o_route;
  logic [3:0] o_dp1_eq, o_dp3_eq;
  logic [6:0] tgt;
  logic [7:0] v, r;
  int fails, cmp_count;
  // open-drain data line with pull-up
  assign i_sda = m_oe_n & (o_sda_oe_n | o_sda);
  rdc_config dut (.i_clk_sys, .i_nrst, .i_i2c_mode, .i_display_mode_pin, .i_usb_mode_pin,
    .i_orientation_pin, .i_display_eq_pins, .i_address_strap_high, .i_address_strap_low,
    .i_scl, .i_sda, .o_sda, .o_sda_oe_n, .o_route, .o_dp1_eq, .o_dp3_eq);
  rdc_i2c_master m (.i_clk_sys, .i_sda, .o_scl(i_scl), .o_sda_oe_n(m_oe_n));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  function automatic rdc_route_t route_of(input logic [1:0] c, input logic f);
    return '{c[0], c[1], c == CFG_DP4, f};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic open_tgt(input logic rw, input logic [7:0] exp_ack);
    logic [7:0] q;
    logic a;
    m.start();
    m.xfer({tgt, rw}, 1'b1, q, a);
    chk("address ack", {7'h0, a}, exp_ack);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    open_tgt(1'b0, 8'h1);
    m.xfer(ptr, 1'b1, q, a);
    m.xfer(d, 1'b1, q, a);
    m.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    open_tgt(1'b0, 8'h1);
    m.xfer(ptr, 1'b1, d, a);
    open_tgt(1'b1, 8'h1);
    m.xfer(8'hff, 1'b1, d, a);
    m.stop();
  endtask
  task automatic do_reset();
    @(posedge i_clk_sys);
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
  endtask
  initial begin
    #900000;
    fails++;
    complete_run();
  end
  initial begin
    {i_nrst, i_i2c_mode, i_display_mode_pin, i_usb_mode_pin, i_orientation_pin} = '0;
    i_address_strap_high = STRAP_FLOAT;
    i_address_strap_low = STRAP_FLOAT;
    tgt = 7'h12;
    fails = 0;
    cmp_count = 0;
    eq_set = 2'h2;
    i_display_eq_pins = eq_set;
    void'($urandom(56));
    do_reset();
    i_display_eq_pins <= ~eq_set;
    for (int k = 0; k < 24; k++) begin
      {i_display_mode_pin, i_usb_mode_pin, i_orientation_pin} <= 3'($urandom);
      repeat (3) @(posedge i_clk_sys);
      v = 8'(route_of({i_display_mode_pin, i_usb_mode_pin}, i_orientation_pin));
      chk("pin route", 8'(o_route), v);
    end
    rd(GEN_CTRL_OFS, r);
    chk("general reset", r, GEN_CTRL_RST);
    wr(DP13_EQ_OFS, 8'ha5);
    rd(DP13_EQ_OFS, r);
    chk("eq mirror", r, {2'h0, eq_set, 2'h0, eq_set});
    i_i2c_mode <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      v = 8'($urandom);
      wr(GEN_CTRL_OFS, {v[7:5], 2'h0, v[2], 2'(c)});
      chk("reg route", 8'(o_route), 8'(route_of(2'(c), v[2])));
      rd(GEN_CTRL_OFS, r);
      chk("general readback", r, {5'h0, v[2], 2'(c)});
    end
    for (int p = 0; p < 2; p++) begin
      i_display_mode_pin <= p[0];
      wr(GEN_CTRL_OFS, 8'h09);
      chk("pin display enable", 8'(o_route), 8'(route_of({p[0], 1'b1}, 1'b0)));
    end
    wr(GEN_CTRL_OFS, 8'h11);
    v = 8'($urandom);
    wr(DP13_EQ_OFS, v);
    rd(DP13_EQ_OFS, r);
    chk("eq written", r, v);
    chk("eq outputs", {o_dp1_eq, o_dp3_eq}, v);
    wr(GEN_CTRL_OFS, 8'h01);
    rd(DP13_EQ_OFS, r);
    chk("eq from pins", r, {2'h0, eq_set, 2'h0, eq_set});
    rd(8'h05, r);
    chk("unmapped read", r, UNMAPPED_RD);
    i_address_strap_high <= STRAP_LOW;
    i_address_strap_low <= STRAP_HIGH;
    m.half = 7;
    do_reset();
    open_tgt(1'b0, 8'h0);
    m.stop();
    tgt = 7'h10;
    rd(GEN_CTRL_OFS, r);
    chk("strap address read", r, GEN_CTRL_RST);
    complete_run();
  end
endmodule
`default_nettype wire
